//--- hdl/pesd_decoder.sv
`include "pesd_defines.svh"

module pesd_decoder (
    input  wire logic        clk_i,            // core clock
    input  wire logic        reset_n_i,        // async reset, active low
    input  wire logic [31:0] seq_sel_a_i,      // sequencer_event_sel_reg_a
    input  wire logic [31:0] seq_sel_b_i,      // sequencer_event_sel_reg_b
    input  wire logic [31:0] br_sel_a_i,       // branch_unit_event_sel_reg_a
    input  wire logic [31:0] br_sel_b_i,       // branch_unit_event_sel_reg_b
    input  wire logic [15:0] ccr_4_i,          // counter_configuration_reg 4
    input  wire logic [15:0] ccr_5_i,          // counter_configuration_reg 5
    input  wire logic [15:0] ccr_6_i,          // counter_configuration_reg 6
    input  wire logic [15:0] ccr_7_i,          // counter_configuration_reg 7
    input  wire logic        delivery_handover_event_i, // to sequencer pulse
    input  wire logic        uop_write_i,      // valid queue write pulse
    input  wire logic        src_trace_building_i,   // write in build mode
    input  wire logic        src_trace_delivering_i, // write in deliver mode
    input  wire logic        src_rom_i,        // write from microcode rom
    input  wire logic        br_retire_i,      // branch retires
    input  wire logic        br_mispred_i,     // retiring branch mispredicted
    input  wire logic        br_cond_i,        // conditional jump
    input  wire logic        br_call_i,        // indirect call
    input  wire logic        br_return_i,      // return
    input  wire logic        br_indirect_i,    // indirect jump
    output logic       [3:0] cnt_inc_o         // increment, counters 7..4
);

    // ------------------------------------------------------------
    // event decode per selection register
    // ------------------------------------------------------------
    function automatic pesd_pkg::pesd_event_t seq_decode(
        input logic [31:0] sel
    );
        logic [6:0] code;
        code = sel[`PESD_SEL7_HI:`PESD_SEL7_LO];
        if (code == `PESD_HANDOVER_SEL)
            seq_decode = pesd_pkg::PESD_EV_HANDOVER;
        else if (code == `PESD_QWRITE_SEL)
            seq_decode = pesd_pkg::PESD_EV_QWRITE;
        else
            seq_decode = pesd_pkg::PESD_EV_NONE;
    endfunction

    // branch unit uses a 6-bit select field, bit 31 is ignored
    function automatic pesd_pkg::pesd_event_t br_decode(
        input logic [31:0] sel
    );
        logic [5:0] code;
        code = sel[`PESD_SEL6_HI:`PESD_SEL7_LO];
        if (code == `PESD_MISPRED_SEL)
            br_decode = pesd_pkg::PESD_EV_MISPRED;
        else if (code == `PESD_RETBR_SEL)
            br_decode = pesd_pkg::PESD_EV_RETBR;
        else
            br_decode = pesd_pkg::PESD_EV_NONE;
    endfunction

    // ------------------------------------------------------------
    // qualified event for one register and its counter's config
    // ------------------------------------------------------------
    function automatic logic seq_hit(
        input logic [31:0] sel,
        input logic [15:0] ccr,
        input logic        handover,
        input logic        qw,
        input logic        s_build,
        input logic        s_deliv,
        input logic        s_rom
    );
        logic [15:0] m;
        logic [2:0]  cfg;
        m       = sel[`PESD_MASK_HI:`PESD_MASK_LO];
        cfg     = ccr[`PESD_CFG_HI:`PESD_CFG_LO];
        seq_hit = 1'b0;
        case (seq_decode(sel))
            pesd_pkg::PESD_EV_HANDOVER: begin
                seq_hit = (cfg == `PESD_HANDOVER_CFG)
                        & m[`PESD_M_HANDOVER] & handover;
            end
            pesd_pkg::PESD_EV_QWRITE: begin
                seq_hit = (cfg == `PESD_QWRITE_CFG) & qw
                        & ((m[`PESD_M_BUILD]   & s_build)
                        |  (m[`PESD_M_DELIVER] & s_deliv)
                        |  (m[`PESD_M_ROM]        & s_rom));
            end
            default: seq_hit = 1'b0;
        endcase
    endfunction

    // no overcount filter: replayed trace builds may count again
    function automatic logic br_hit(
        input logic [31:0] sel,
        input logic [15:0] ccr,
        input logic        retire,
        input logic        mispred,
        input logic [3:0]  kind // indirect, return, call, cond
    );
        logic [15:0] m;
        logic [2:0]  cfg;
        logic        typ;
        m   = sel[`PESD_MASK_HI:`PESD_MASK_LO];
        cfg = ccr[`PESD_CFG_HI:`PESD_CFG_LO];
        typ = (m[`PESD_M_COND]   & kind[0])
            | (m[`PESD_M_CALL]   & kind[1])
            | (m[`PESD_M_RETURN] & kind[2])
            | (m[`PESD_M_INDIRECT] & (kind[1] | kind[2] | kind[3]));
        br_hit = 1'b0;
        case (br_decode(sel))
            pesd_pkg::PESD_EV_MISPRED: begin
                br_hit = (cfg == `PESD_MISPRED_CFG)
                       & retire & mispred & typ;
            end
            pesd_pkg::PESD_EV_RETBR: begin
                br_hit = (cfg == `PESD_RETBR_CFG) & retire & typ;
            end
            default: br_hit = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // counter routing
    // ------------------------------------------------------------
    logic [3:0] inc_ff;
    logic [3:0] nxt_inc;
    logic [3:0] kind;
    logic [3:0] seq_part;
    logic [3:0] br_part;

    assign kind = {br_indirect_i, br_return_i, br_call_i, br_cond_i};

    always_comb begin
        seq_part = 4'h0;
        br_part  = 4'h0;
        // register a reaches only 4 and 5, register b only 6 and 7
        seq_part[0] = seq_hit(seq_sel_a_i, ccr_4_i,
            delivery_handover_event_i, uop_write_i, src_trace_building_i,
            src_trace_delivering_i, src_rom_i);
        seq_part[1] = seq_hit(seq_sel_a_i, ccr_5_i,
            delivery_handover_event_i, uop_write_i, src_trace_building_i,
            src_trace_delivering_i, src_rom_i);
        seq_part[2] = seq_hit(seq_sel_b_i, ccr_6_i,
            delivery_handover_event_i, uop_write_i, src_trace_building_i,
            src_trace_delivering_i, src_rom_i);
        seq_part[3] = seq_hit(seq_sel_b_i, ccr_7_i,
            delivery_handover_event_i, uop_write_i, src_trace_building_i,
            src_trace_delivering_i, src_rom_i);
        br_part[0] = br_hit(br_sel_a_i, ccr_4_i, br_retire_i,
            br_mispred_i, kind);
        br_part[1] = br_hit(br_sel_a_i, ccr_5_i, br_retire_i,
            br_mispred_i, kind);
        br_part[2] = br_hit(br_sel_b_i, ccr_6_i, br_retire_i,
            br_mispred_i, kind);
        br_part[3] = br_hit(br_sel_b_i, ccr_7_i, br_retire_i,
            br_mispred_i, kind);
        // a counter's config picks one unit; both can never be legal
        nxt_inc = seq_part | br_part;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            inc_ff <= `PESD_RST_INC;
        end else begin
            inc_ff <= nxt_inc;
        end
    end

    assign cnt_inc_o = inc_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [6:0] sa_code;
    logic [2:0] c4_cfg;
    logic [5:0] ba_code;
    logic [2:0] c6_cfg;
    logic [15:0] sa_m;
    logic [15:0] bb_m;
    logic [6:0] sb_code;
    logic [2:0] c5_cfg;
    assign sa_code = seq_sel_a_i[`PESD_SEL7_HI:`PESD_SEL7_LO];
    assign ba_code = br_sel_a_i[`PESD_SEL6_HI:`PESD_SEL7_LO];
    assign c4_cfg  = ccr_4_i[`PESD_CFG_HI:`PESD_CFG_LO];
    assign c6_cfg  = ccr_6_i[`PESD_CFG_HI:`PESD_CFG_LO];
    assign sa_m    = seq_sel_a_i[`PESD_MASK_HI:`PESD_MASK_LO];
    assign bb_m    = br_sel_b_i[`PESD_MASK_HI:`PESD_MASK_LO];
    assign sb_code = seq_sel_b_i[`PESD_SEL7_HI:`PESD_SEL7_LO];
    assign c5_cfg  = ccr_5_i[`PESD_CFG_HI:`PESD_CFG_LO];

    sequence s_handover_armed;
        sa_code == 7'h05 && sa_m[0] && c4_cfg == 3'h0;
    endsequence

    // armed setting and the hand-over pulse in the same cycle
    sequence s_handover_seen;
        s_handover_armed ##0 delivery_handover_event_i;
    endsequence

    AST_HANDOVER_COUNT: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_handover_seen |=> cnt_inc_o[0])
        else $error("handover not counted on counter 4");

    AST_QWRITE_ROM: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h09 && c4_cfg == 3'h0 && sa_m[2] && uop_write_i
         && src_rom_i) |=> cnt_inc_o[0])
        else $error("rom queue write not counted");

    AST_QWRITE_BUILD: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h09 && c4_cfg == 3'h0 && sa_m[0] && uop_write_i
         && src_trace_building_i) |=> cnt_inc_o[0])
        else $error("build-mode queue write not counted");

    AST_QWRITE_DELIVER: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h09 && c4_cfg == 3'h0 && sa_m[1] && uop_write_i
         && src_trace_delivering_i) |=> cnt_inc_o[0])
        else $error("deliver-mode queue write not counted");

    AST_QWRITE_NOMATCH: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h09 && c4_cfg == 3'h0
         && !(sa_m[0] && src_trace_building_i)
         && !(sa_m[1] && src_trace_delivering_i)
         && !(sa_m[2] && src_rom_i)) |=> !cnt_inc_o[0])
        else $error("queue write counted without source match");

    AST_QWRITE_NO_VALID: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h09 && c4_cfg == 3'h0 && !uop_write_i)
        |=> !cnt_inc_o[0])
        else $error("queue count without a valid write");

    AST_MISPRED_COND: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (ba_code == 6'h05 && ccr_4_i[15:13] == 3'h2 && br_retire_i
         && br_mispred_i && br_cond_i
         && br_sel_a_i[10]) |=> cnt_inc_o[0])
        else $error("mispredicted conditional not counted");

    AST_MISPRED_NEEDS_MISS: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (ba_code == 6'h05 && c4_cfg == 3'h2 && !br_mispred_i)
        |=> !cnt_inc_o[0])
        else $error("mispredict count without misprediction");

    AST_INDIRECT_RETURN: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (br_sel_b_i[30:25] == 6'h05 && c6_cfg == 3'h2 && bb_m[4]
         && br_retire_i && br_mispred_i && br_return_i)
        |=> cnt_inc_o[2])
        else $error("indirect mask missed a return");

    AST_CFG_MISMATCH: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (c4_cfg != 3'h0 && c4_cfg != 3'h2) |=> !cnt_inc_o[0])
        else $error("count with unmatched config select");

    AST_RETBR_COUNT: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (ba_code == 6'h04 && c4_cfg == 3'h2 && br_retire_i
         && br_sel_a_i[12] && br_return_i) |=> cnt_inc_o[0])
        else $error("retired branch not counted");

    AST_ROUTE_B_ONLY: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (seq_sel_b_i[31:25] == 7'h00 && br_sel_b_i[30:25] == 6'h00)
        |=> cnt_inc_o[3:2] == 2'h0)
        else $error("counters 6/7 fired with register b idle");

    AST_ROUTE_A_ONLY: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h00 && ba_code == 6'h00)
        |=> cnt_inc_o[1:0] == 2'h0)
        else $error("counters 4/5 fired with register a idle");

    AST_HANDOVER_NO_MASK: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sa_code == 7'h05 && c4_cfg == 3'h0 && !sa_m[0])
        |=> !cnt_inc_o[0])
        else $error("handover counted without its mask bit");

    AST_MISPRED_CALL: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (ba_code == 6'h05 && c5_cfg == 3'h2 && br_sel_a_i[11] && br_retire_i
         && br_mispred_i && br_call_i) |=> cnt_inc_o[1])
        else $error("mispredicted indirect call not counted");

    AST_RETBR_NEEDS_RETIRE: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (ba_code == 6'h04 && c5_cfg == 3'h2 && !br_retire_i)
        |=> !cnt_inc_o[1])
        else $error("retired branch count without a retirement");

    AST_SEQ_B_QWRITE: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sb_code == 7'h09 && c6_cfg == 3'h0 && seq_sel_b_i[11] && uop_write_i
         && src_rom_i) |=> cnt_inc_o[2])
        else $error("register b queue write not counted on counter 6");

endmodule

//--- hdl/pesd_defines.svh
`ifndef PESD_DEFINES_SVH
`define PESD_DEFINES_SVH

// ----------------------------------------------------------------
// event selection field layout
// ----------------------------------------------------------------
`define PESD_SEL7_HI       31
`define PESD_SEL7_LO       25
`define PESD_SEL6_HI       30
`define PESD_MASK_HI       24
`define PESD_MASK_LO       9
`define PESD_CFG_HI        15
`define PESD_CFG_LO        13

// ----------------------------------------------------------------
// event encodings
// ----------------------------------------------------------------
`define PESD_HANDOVER_SEL  7'h05
`define PESD_HANDOVER_CFG  3'h0
`define PESD_QWRITE_SEL    7'h09
`define PESD_QWRITE_CFG    3'h0
`define PESD_MISPRED_SEL   6'h05
`define PESD_MISPRED_CFG   3'h2
`define PESD_RETBR_SEL     6'h04
`define PESD_RETBR_CFG     3'h2

// ----------------------------------------------------------------
// mask bit positions
// ----------------------------------------------------------------
`define PESD_M_HANDOVER    0
`define PESD_M_BUILD       0
`define PESD_M_DELIVER     1
`define PESD_M_ROM         2
`define PESD_M_COND        1
`define PESD_M_CALL        2
`define PESD_M_RETURN      3
`define PESD_M_INDIRECT    4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PESD_RST_INC       4'h0

`endif

//--- hdl/pesd_pkg.sv
package pesd_pkg;
    // which event a selection register currently picks
    typedef enum logic [2:0] {
        PESD_EV_NONE     = 3'h0,
        PESD_EV_HANDOVER = 3'h1,
        PESD_EV_QWRITE   = 3'h3,
        PESD_EV_MISPRED  = 3'h2,
        PESD_EV_RETBR    = 3'h6
    } pesd_event_t;
endpackage

//--- sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // stimulus and bookkeeping
    // ----------------------------------------------------------------
    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [31:0] sel_q [4];  // seq a, seq b, branch a, branch b
    logic [15:0] ccr_q [4];  // counters 4..7
    logic [10:0] ev    = 11'h000;
    logic [3:0]  cnt_inc_o;
    logic [3:0]  exp_q = 4'h0;
    integer      seed  = 32'h7037;
    int          bad_count    = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    // ev: 0 handover, 1 qwrite, 2 build, 3 deliver, 4 rom, 5 retire,
    // 6 mispred, 7 cond, 8 call, 9 return, 10 indirect jump
    pesd_decoder i_dut (
        .clk_i                     (clk_i),
        .reset_n_i                 (reset_n_i),
        .seq_sel_a_i               (sel_q[0]),
        .seq_sel_b_i               (sel_q[1]),
        .br_sel_a_i                (sel_q[2]),
        .br_sel_b_i                (sel_q[3]),
        .ccr_4_i                   (ccr_q[0]),
        .ccr_5_i                   (ccr_q[1]),
        .ccr_6_i                   (ccr_q[2]),
        .ccr_7_i                   (ccr_q[3]),
        .delivery_handover_event_i (ev[0]),
        .uop_write_i               (ev[1]),
        .src_trace_building_i      (ev[2]),
        .src_trace_delivering_i    (ev[3]),
        .src_rom_i                 (ev[4]),
        .br_retire_i               (ev[5]),
        .br_mispred_i              (ev[6]),
        .br_cond_i                 (ev[7]),
        .br_call_i                 (ev[8]),
        .br_return_i               (ev[9]),
        .br_indirect_i             (ev[10]),
        .cnt_inc_o                 (cnt_inc_o)
    );

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // expectation and checking
    // ----------------------------------------------------------------
    function automatic logic [3:0] calc_inc();
        logic [3:0]  r;
        logic [31:0] sq;
        logic [31:0] bq;
        logic [2:0]  cfg;
        logic        ty;
        r = 4'h0;
        for (int n = 0; n < 4; n++) begin
            sq  = sel_q[n / 2];
            bq  = sel_q[2 + n / 2];
            cfg = ccr_q[n][15:13];
            ty  = (bq[10] & ev[7]) | (bq[11] & ev[8]) | (bq[12] & ev[9])
                | (bq[13] & (ev[8] | ev[9] | ev[10]));
            if (cfg == 3'h0 && sq[31:25] == 7'h05 && sq[9] && ev[0])
                r[n] = 1'b1;
            if (cfg == 3'h0 && sq[31:25] == 7'h09 && ev[1]
                && ((sq[9] & ev[2]) | (sq[10] & ev[3]) | (sq[11] & ev[4])))
                r[n] = 1'b1;
            if (cfg == 3'h2 && bq[30:25] == 6'h05 && ev[5] && ev[6] && ty)
                r[n] = 1'b1;
            if (cfg == 3'h2 && bq[30:25] == 6'h04 && ev[5] && ty)
                r[n] = 1'b1;
        end
        return r;
    endfunction

    task automatic check(input string what, input logic [3:0] seen,
                         input logic [3:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    // one cycle: check the previous cycle's answer, then drive anew
    task automatic tick();
        @(posedge clk_i);
        #1;
        check("cnt_inc_o", cnt_inc_o, exp_q);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    task automatic rand_regs();
        int k;
        for (int i = 0; i < 4; i++) begin
            sel_q[i] = $random(seed);
            ccr_q[i] = 16'($random(seed));
            k = $unsigned($random(seed)) % 4;
            if (i < 2 && k < 3)
                sel_q[i][31:25] = (k == 0) ? 7'h05 : 7'h09;
            if (i >= 2 && k < 3)
                sel_q[i][30:25] = (k == 1) ? 6'h04 : 6'h05;
            k = $unsigned($random(seed)) % 3;
            if (k < 2)
                ccr_q[i][15:13] = (k == 0) ? 3'h0 : 3'h2;
        end
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            sel_q[i] = 32'h0000_0000;
            ccr_q[i] = 16'h0000;
        end
        repeat (16) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        tick();

        // random settings, held while random events stream past
        for (int blk = 0; blk < 60; blk++) begin
            rand_regs();
            for (int c = 0; c < 16; c++) begin
                ev    = 11'($random(seed));
                exp_q = calc_inc();
                tick();
            end
        end
        $display("test random done");

        // each mask bit alone against each single source, both pairings
        for (int sw = 0; sw < 2; sw++) begin
            for (int b = 0; b < 5; b++) begin
                sel_q[sw]     = {7'h09, 16'h0001 << b, 9'h000};
                sel_q[1 - sw] = {7'h05, 16'h0001 << b, 9'h000};
                sel_q[2 + sw] = {1'b1, 6'h05, 16'h0001 << b, 9'h000};
                sel_q[3 - sw] = {1'b0, 6'h04, 16'h0001 << b, 9'h000};
                ccr_q[0] = 16'h0000;
                ccr_q[1] = 16'h4000;
                ccr_q[2] = 16'h1fff;
                ccr_q[3] = 16'h5fff;
                for (int e = 0; e < 11; e++) begin
                    ev = 11'h001 << e;
                    if (e >= 2 && e <= 4)
                        ev[1] = 1'b1;
                    if (e >= 7)
                        ev[6:5] = 2'h3;
                    exp_q = calc_inc();
                    tick();
                end
            end
        end
        $display("test directed done");

        // reset in mid-stream clears the increments at once
        rand_regs();
        ev    = 11'h7ff;
        exp_q = calc_inc();
        tick();
        reset_n_i = 1'b0;
        exp_q     = 4'h0;
        #1 check("cnt_inc_o in reset", cnt_inc_o, 4'h0);
        repeat (3) tick();
        reset_n_i = 1'b1;
        ev        = 11'h000;
        tick();
        ev    = 11'h7ff;
        exp_q = calc_inc();
        tick();
        ev    = 11'h000;
        exp_q = 4'h0;
        tick();
        $display("test reset done");
        finish_test();
    end
endmodule
